//--- hdl/flash_seq_pkg.sv
// Package: register map, field codes and types for the flash sequencer
package flash_seq_pkg;

  // Register byte offsets on the bus (one aligned word each)
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_EXCMD = 8'h08;
  localparam logic [7:0] OFS_START = 8'h0C;
  localparam logic [7:0] OFS_END = 8'h10;
  localparam logic [7:0] OFS_ERRADR = 8'h14;
  localparam logic [7:0] OFS_WBUF0 = 8'h18;
  localparam logic [7:0] OFS_UID0 = 8'h28;
  localparam logic [7:0] OFS_SECMON = 8'h38;
  localparam logic [7:0] OFS_CWAIT = 8'h3C;
  localparam logic [7:0] OFS_DWAIT = 8'h40;
  localparam logic [7:0] OFS_IRQST = 8'h44;
  localparam logic [7:0] OFS_IRQMSK = 8'h48;
  localparam logic [7:0] OFS_STOP = 8'h4C;
  localparam logic [7:0] OFS_STATUS = 8'h50;
  localparam logic [7:0] OFS_PROT = 8'h54;

  // Operating mode codes
  localparam logic [1:0] MODE_READ = 2'h0;
  localparam logic [1:0] MODE_CODE_PE = 2'h1;
  localparam logic [1:0] MODE_DATA_PE = 2'h2;

  // Software command codes
  localparam logic [3:0] CMD_PROGRAM = 4'h1;
  localparam logic [3:0] CMD_BLANK = 4'h3;
  localparam logic [3:0] CMD_BLOCK_ERASE = 4'h4;
  localparam logic [3:0] CMD_ALL_ERASE = 4'h6;
  localparam logic [2:0] EXCMD_STARTUP = 3'h1;
  localparam logic [2:0] EXCMD_WINDOW = 3'h2;

  // Code flash map: 256 KB base; 128 KB and 64 KB bases
  localparam logic [15:0] CODE_BASE_256K = 16'hFFFC;
  localparam logic [15:0] CODE_BASE_128K = 16'hFFFE;
  localparam logic [15:0] CODE_BASE_64K = 16'hFFFF;
  localparam logic [15:0] DATA_BASE = 16'h0010;
  localparam logic [15:0] DATA_LAST = 16'h0010;
  localparam logic [3:0] STARTUP_LAST_BLOCK = 4'h7;

  // Reset value, command run length and identifier seed
  localparam logic [3:0] WAIT_RESET = 4'h0;
  localparam logic [2:0] EXEC_CYCLES = 3'h4;
  localparam logic [31:0] UID_SEED = 32'h5A5A_0000;  // Arbitrary value

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_DONE = 2'b11
  } seq_state_e;

  // Extra-area contents
  typedef struct packed {
    logic startup_swap;
    logic window_protect;
    logic [15:0] window_start;
    logic [15:0] window_end;
  } extra_area_s;

endpackage

//--- hdl/flash_program_erase_sequencer.sv
// Flash program/erase command sequencer with Wishbone register file
`timescale 1ns/100ps

// How it works
// RULE_01: Mode 00 read, 01 code-flash program/erase, 10 data-flash; 11 prohibited.
// RULE_02: Commands: 0001 program, 0011 blank check, 0100 block, 0110 all erase.
// RULE_03: Extra commands: 001 start-up info or window protect, 010 window info.
// RULE_04: Ready interrupt fires when a command or forced stop completes.
// RULE_05: Start-up protection covers code blocks 0 to 7; code checks no block, refuses all erase if window protect set, swap clear.
// RULE_06: Self-programming outside the configured window is refused.
// RULE_07: Code flash stays readable while data flash is programmed.
// RULE_08: Start address upper half held in a 16-bit register.
// RULE_09: End address upper half held in a 16-bit register.
// RULE_10: Four write buffer words, 0 to 3, loaded before program.
// RULE_11: Code flash ends at FFFFFFFF; base set by capacity 256, 128 or 64 KB.
// RULE_12: User area up to 256 KB, data area up to 8 KB.
// RULE_13: Unique identifier readable as four 32-bit read-only words.
// RULE_14: Window protect flag reports protection, set by extra protect command.
// RULE_15: Extra area holds start-up, window bounds and identifier.
// RULE_16: Code and data read wait cycles each have a setting register.
// RULE_17: Failing address upper half kept in a 16-bit monitor register.
// RULE_18: Command writes ignored while busy; accepted only after ready.
module flash_program_erase_sequencer (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic err_o,
  // Capacity select: 0 256 KB, 1 128 KB, 2 64 KB
  input wire logic [1:0] capacity_i,
  // Code flash fetch path
  input wire logic code_fetch_i,
  output logic code_fetch_ok_o,
  output logic [15:0] code_base_o,
  output logic [3:0] code_wait_o,
  output logic [3:0] data_wait_o,
  // Interrupt
  output logic sequencer_ready_irq
);
  import flash_seq_pkg::*;

  logic [1:0] mode_r;
  logic [3:0] cmd_r;
  logic [2:0] excmd_r;
  logic [15:0] start_address_high_r;
  logic [15:0] end_address_high_r;
  logic [15:0] error_address_monitor_high_r;
  logic [31:0] program_data_buffer [4];
  logic [31:0] unique_identifier_word [4];
  logic [3:0] code_read_wait_setting_r;
  logic [3:0] data_read_wait_setting_r;
  extra_area_s extra_r;
  logic [1:0] irq_status_r;
  logic [1:0] irq_mask_r;
  logic failed_r;
  seq_state_e state_r;
  logic [2:0] exec_cnt_r;
  logic stop_r;
  logic ack_r;
  logic [31:0] rdata;
  logic access;
  logic wr;
  logic rd;
  logic mapped;
  logic busy;
  logic cmd_go;
  logic excmd_go;
  logic done_evt;
  logic cmd_bad;
  logic [15:0] code_base;

  // Whether a word-aligned address falls inside a four-word group
  function automatic logic in_group(input logic [7:0] a, input logic [7:0] base);
    in_group = (a >= base) && (a < base + 8'h10) && (a[1:0] == 2'b00);
  endfunction

  // Code flash base from capacity strap
  always_comb begin
    if (capacity_i == 2'd1) begin
      code_base = CODE_BASE_128K;  // see RULE_11
    end else if (capacity_i == 2'd2) begin
      code_base = CODE_BASE_64K;  // see RULE_11
    end else begin
      code_base = CODE_BASE_256K;  // see RULE_11, see RULE_12
    end
  end

  // A request is taken once; the answer cycle (ack or err) blocks a second take
  assign access = cyc_i && stb_i && !ack_r && !err_o;
  assign wr = access && we_i && mapped;
  assign rd = access && !we_i && mapped;
  assign busy = (state_r != ST_IDLE);

  // Command launch: any code in a program/erase mode when idle; unknown codes then fail
  assign cmd_go = wr && (adr_i == OFS_CMD) && sel_i[0] && !busy  // see RULE_18
                  && (mode_r == MODE_CODE_PE || mode_r == MODE_DATA_PE);
  assign excmd_go = wr && (adr_i == OFS_EXCMD) && sel_i[0] && !busy  // see RULE_18
                    && (mode_r == MODE_CODE_PE);
  assign done_evt = (state_r == ST_DONE);

  // Address decode and read mux
  always_comb begin
    mapped = 1'b1;
    rdata = 32'h0000_0000;
    if (adr_i == OFS_MODE) begin
      rdata = {30'h0, mode_r};
    end else if (adr_i == OFS_CMD) begin
      rdata = {28'h0, cmd_r};
    end else if (adr_i == OFS_EXCMD) begin
      rdata = {29'h0, excmd_r};
    end else if (adr_i == OFS_START) begin
      rdata = {16'h0, start_address_high_r};
    end else if (adr_i == OFS_END) begin
      rdata = {16'h0, end_address_high_r};
    end else if (adr_i == OFS_ERRADR) begin
      rdata = {16'h0, error_address_monitor_high_r};  // see RULE_17
    end else if (in_group(adr_i, OFS_WBUF0)) begin
      rdata = program_data_buffer[adr_i[3:2] - OFS_WBUF0[3:2]];
    end else if (in_group(adr_i, OFS_UID0)) begin
      rdata = unique_identifier_word[adr_i[3:2] - OFS_UID0[3:2]];  // see RULE_13
    end else if (adr_i == OFS_SECMON) begin
      rdata = {31'h0, extra_r.window_protect};  // see RULE_14
    end else if (adr_i == OFS_CWAIT) begin
      rdata = {28'h0, code_read_wait_setting_r};
    end else if (adr_i == OFS_DWAIT) begin
      rdata = {28'h0, data_read_wait_setting_r};
    end else if (adr_i == OFS_IRQST) begin
      rdata = {30'h0, irq_status_r};
    end else if (adr_i == OFS_IRQMSK) begin
      rdata = {30'h0, irq_mask_r};
    end else if (adr_i == OFS_STOP) begin
      rdata = 32'h0000_0000;
    end else if (adr_i == OFS_STATUS) begin
      rdata = {29'h0, extra_r.startup_swap, failed_r, busy};
    end else if (adr_i == OFS_PROT) begin
      rdata = {extra_r.window_end, extra_r.window_start};
    end else begin
      mapped = 1'b0;
    end
  end

  // Bus answer: one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_o <= 32'h0000_0000;
      err_o <= 1'b0;
    end else begin
      ack_r <= access && mapped;
      err_o <= access && !mapped;  // Unmapped address answers with err
      dat_o <= rd ? rdata : 32'h0000_0000;
    end
  end
  assign ack_o = ack_r;

  // Software control registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_r <= MODE_READ;
      start_address_high_r <= 16'h0000;
      end_address_high_r <= 16'h0000;
      code_read_wait_setting_r <= WAIT_RESET;
      data_read_wait_setting_r <= WAIT_RESET;
      irq_mask_r <= 2'h0;
    end else if (wr && sel_i[0]) begin
      if (adr_i == OFS_MODE && !busy && dat_i[1:0] != 2'h3) begin
        mode_r <= dat_i[1:0];  // see RULE_01
      end else if (adr_i == OFS_START && sel_i[1]) begin
        start_address_high_r <= dat_i[15:0];  // see RULE_08
      end else if (adr_i == OFS_END && sel_i[1]) begin
        end_address_high_r <= dat_i[15:0];  // see RULE_09
      end else if (adr_i == OFS_CWAIT) begin
        code_read_wait_setting_r <= dat_i[3:0];  // see RULE_16
      end else if (adr_i == OFS_DWAIT) begin
        data_read_wait_setting_r <= dat_i[3:0];  // see RULE_16
      end else if (adr_i == OFS_IRQMSK) begin
        irq_mask_r <= dat_i[1:0];
      end
    end
  end

  // Write buffer words, frozen while a command runs
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_wbuf
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          program_data_buffer[gi] <= 32'hFFFF_FFFF;
        end else if (wr && !busy && adr_i == OFS_WBUF0 + 8'(gi * 4)) begin
          program_data_buffer[gi] <= dat_i;  // see RULE_10
        end
      end
      // Identifier words are fixed, read-only
      assign unique_identifier_word[gi] = UID_SEED | 32'(gi);  // see RULE_15
    end
  endgenerate

  // A command aimed at a protected or unknown target fails at launch
  always_comb begin
    cmd_bad = 1'b0;
    if (cmd_go) begin
      if (dat_i[3:0] != CMD_PROGRAM && dat_i[3:0] != CMD_BLANK
          && dat_i[3:0] != CMD_BLOCK_ERASE && dat_i[3:0] != CMD_ALL_ERASE) begin
        cmd_bad = 1'b1;  // see RULE_02
      end else if (mode_r == MODE_CODE_PE && dat_i[3:0] != CMD_BLANK) begin
        if (start_address_high_r < code_base) begin
          cmd_bad = 1'b1;  // see RULE_11
        end else if (extra_r.window_protect
                     && (start_address_high_r < extra_r.window_start
                         || end_address_high_r > extra_r.window_end)) begin
          cmd_bad = 1'b1;  // see RULE_06
        end else if (!extra_r.startup_swap && dat_i[3:0] == CMD_ALL_ERASE
                     && extra_r.window_protect) begin
          cmd_bad = 1'b1;  // see RULE_05
        end
      end else if (mode_r == MODE_DATA_PE && (start_address_high_r < DATA_BASE
                   || end_address_high_r > DATA_LAST)) begin
        cmd_bad = 1'b1;  // see RULE_12
      end
    end
  end

  // Sequencer: launch, timed execution, forced stop, completion
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
      exec_cnt_r <= 3'h0;
      cmd_r <= 4'h0;
      excmd_r <= 3'h0;
      failed_r <= 1'b0;
      stop_r <= 1'b0;
      error_address_monitor_high_r <= 16'h0000;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (cmd_go || excmd_go) begin
            state_r <= ST_RUN;
            exec_cnt_r <= EXEC_CYCLES;
            stop_r <= 1'b0;
            failed_r <= cmd_bad || (excmd_go && dat_i[2:0] != EXCMD_STARTUP
                        && dat_i[2:0] != EXCMD_WINDOW);  // see RULE_03
            if (cmd_go) begin
              cmd_r <= dat_i[3:0];
            end else begin
              excmd_r <= dat_i[2:0];
            end
            if (cmd_bad) begin
              error_address_monitor_high_r <= start_address_high_r;  // see RULE_17
            end
          end
        end
        ST_RUN: begin
          if (wr && adr_i == OFS_STOP && sel_i[0] && dat_i[0]) begin
            stop_r <= 1'b1;  // Forced stop ends early
            state_r <= ST_DONE;
          end else if (exec_cnt_r == 3'h1) begin
            state_r <= ST_DONE;
          end else begin
            exec_cnt_r <= exec_cnt_r - 3'h1;
          end
        end
        ST_DONE: begin
          state_r <= ST_IDLE;
          cmd_r <= 4'h0;
          excmd_r <= 3'h0;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Extra-area contents change only by the extra commands
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      extra_r <= '0;
    end else if (done_evt && !failed_r && !stop_r) begin
      if (excmd_r == EXCMD_STARTUP) begin
        extra_r.startup_swap <= start_address_high_r[0];  // see RULE_15
        extra_r.window_protect <= start_address_high_r[1];  // see RULE_14
      end else if (excmd_r == EXCMD_WINDOW) begin
        extra_r.window_start <= start_address_high_r;  // see RULE_15
        extra_r.window_end <= end_address_high_r;
      end
    end
  end

  // Sticky events: bit0 command done, bit1 forced stop done; read clears, set wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_status_r <= 2'h0;
    end else begin
      irq_status_r <= (rd && adr_i == OFS_IRQST ? 2'h0 : irq_status_r)
                      | {done_evt && stop_r, done_evt && !stop_r};  // see RULE_04
    end
  end
  assign sequencer_ready_irq = |(irq_status_r & irq_mask_r);  // see RULE_04

  // Code fetch is blocked only while a code flash command runs
  assign code_fetch_ok_o = code_fetch_i && !(busy && mode_r == MODE_CODE_PE);  // see RULE_07
  assign code_base_o = code_base;
  assign code_wait_o = code_read_wait_setting_r;
  assign data_wait_o = data_read_wait_setting_r;

endmodule // flash_program_erase_sequencer

//--- verification/flash_seq_props.sv
// Port-level checks for the flash program/erase sequencer
`timescale 1ns/100ps
module flash_seq_props
  import flash_seq_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus side
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic err_o,
  // Flash side
  input wire logic [1:0] capacity_i,
  input wire logic code_fetch_i,
  input wire logic code_fetch_ok_o,
  input wire logic [15:0] code_base_o,
  input wire logic [3:0] code_wait_o,
  input wire logic [3:0] data_wait_o,
  input wire logic sequencer_ready_irq
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // First cycle of a read not yet answered
  sequence s_read_req;
    cyc_i && stb_i && !we_i && !ack_o && !err_o;
  endsequence
  // Write answered in this cycle; it took effect at the edge before
  sequence s_write_ack;
    ack_o && we_i && sel_i[0];
  endsequence

  // Code flash base follows capacity
  a_base_full: assert property (capacity_i == 2'h0 |-> code_base_o == 16'hFFFC)
    else $error("code base wrong for 256 KB");
  a_base_half: assert property (capacity_i == 2'h1 |-> code_base_o == 16'hFFFE)
    else $error("code base wrong for 128 KB");
  a_base_quarter: assert property (capacity_i == 2'h2 |-> code_base_o == 16'hFFFF)
    else $error("code base wrong for 64 KB");
  // Identifier words answer with fixed contents
  a_uid_value: assert property (s_read_req ##1 (ack_o && adr_i >= OFS_UID0 && adr_i < OFS_SECMON)
    |-> dat_o == (UID_SEED | 32'((adr_i - OFS_UID0) >> 2)))
    else $error("identifier word wrong");
  // Wait settings reach their outputs one edge after the write
  a_code_wait: assert property (s_write_ack ##0 (adr_i == OFS_CWAIT)
    |=> code_wait_o == $past(dat_i[3:0]))
    else $error("code wait setting not applied");
  a_data_wait: assert property (s_write_ack ##0 (adr_i == OFS_DWAIT)
    |=> data_wait_o == $past(dat_i[3:0]))
    else $error("data wait setting not applied");
  // Places above OFS_PROT get an error answer, never an ack
  a_err_unmapped: assert property (cyc_i && stb_i && !ack_o && !err_o && adr_i > OFS_PROT
    |=> err_o && !ack_o)
    else $error("unmapped access not refused");
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  // Interrupt only drops through a status read or a mask write
  a_irq_fall: assert property ($fell(sequencer_ready_irq)
    |-> $past(cyc_i && stb_i && !ack_o && !we_i && adr_i == OFS_IRQST)
        || $past(cyc_i && stb_i && !ack_o && we_i && adr_i == OFS_IRQMSK))
    else $error("interrupt dropped without cause");
endmodule // flash_seq_props

bind flash_program_erase_sequencer flash_seq_props u_props (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
  .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o), .capacity_i(capacity_i),
  .code_fetch_i(code_fetch_i), .code_fetch_ok_o(code_fetch_ok_o), .code_base_o(code_base_o),
  .code_wait_o(code_wait_o), .data_wait_o(data_wait_o),
  .sequencer_ready_irq(sequencer_ready_irq));

//--- verification/tb_flash_program_erase_sequencer.sv
// Self-checking bench for the flash program/erase sequencer
`timescale 1ns/100ps
module tb_flash_program_erase_sequencer;
  import flash_seq_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'hF;
  logic [31:0] dat_i = 32'h0;
  logic [1:0] capacity_i = 2'h0;
  logic code_fetch_i = 1'b1;
  logic [31:0] dat_o;
  logic ack_o, err_o, code_fetch_ok_o, sequencer_ready_irq;
  logic [15:0] code_base_o;
  logic [3:0] code_wait_o, data_wait_o;
  logic [31:0] d;
  logic e;
  int n_errors = 0;
  int num_checks = 0;
  int cycles = 0;

  flash_program_erase_sequencer dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .err_o(err_o), .capacity_i(capacity_i), .code_fetch_i(code_fetch_i),
    .code_fetch_ok_o(code_fetch_ok_o), .code_base_o(code_base_o), .code_wait_o(code_wait_o),
    .data_wait_o(data_wait_o), .sequencer_ready_irq(sequencer_ready_irq));

  initial begin
    forever #5 clk_i = ~clk_i;
  end

  task automatic conclude;
    if (n_errors == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Whole run is a few hundred cycles; a hang is cut off well above that
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      conclude();
    end
  end

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    num_checks++;
    if (got !== ex) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, ex, got);
    end
  endtask

  // One classic cycle, held until ack or err is sampled, then one idle cycle
  task wb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= wd;
    for (int n = 0; n <= 50; n++) begin
      @(posedge clk_i);
      if (ack_o === 1'b1 || err_o === 1'b1) break;
      if (n == 50) n_errors++;
    end
    d = dat_o;
    e = err_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] wd);
    wb(1'b1, a, wd);
  endtask

  task rd(input logic [7:0] a);
    wb(1'b0, a, 32'h0);
  endtask

  // Poll the busy flag; a command lasts only a handful of cycles
  task wait_idle;
    for (int n = 0; n < 20; n++) begin
      rd(OFS_STATUS);
      if (d[0] === 1'b0) break;
    end
  endtask

  task t_reset;
    rd(OFS_MODE);
    chk("mode", 32'h0, d);
    rd(OFS_WBUF0);
    chk("wbuf0", 32'hFFFFFFFF, d);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_UID0 + 8'(4 * i), 32'h0);
      rd(OFS_UID0 + 8'(4 * i));
      chk("uid", UID_SEED | 32'(i), d);
    end
    chk("cwait", {28'h0, WAIT_RESET}, {28'h0, code_wait_o});
  endtask

  task t_regs;
    wr(OFS_START, 32'h1234_5678);
    rd(OFS_START);
    chk("start", 32'h0000_5678, d);
    wr(OFS_END, 32'hFFFF_ABCD);
    rd(OFS_END);
    chk("end", 32'h0000_ABCD, d);
    wr(OFS_ERRADR, 32'h0000_1111);
    rd(OFS_ERRADR);
    chk("erradr", 32'h0, d);
    wr(OFS_WBUF0 + 8'hC, 32'hA5A5_0003);
    rd(OFS_WBUF0 + 8'hC);
    chk("wbuf3", 32'hA5A5_0003, d);
    wr(OFS_CWAIT, 32'h5);
    wr(OFS_DWAIT, 32'h9);
    chk("waits", 32'h95, {24'h0, data_wait_o, code_wait_o});
    rd(8'h60);
    chk("unmapped", 32'h1, {31'h0, e});
    wr(OFS_MODE, 32'h2);
    wr(OFS_MODE, 32'h3);
    rd(OFS_MODE);
    chk("mode held", 32'h2, d);
    for (int c = 0; c < 3; c++) begin
      capacity_i <= 2'(c);
      @(posedge clk_i);
      @(posedge clk_i);
      chk("base", 32'hFFFC + 32'(c == 2 ? 3 : 2 * c), {16'h0, code_base_o});
    end
    capacity_i <= 2'h0;
  endtask

  // Issue one command and judge the interrupt status register and fetch grant
  task run(input logic [1:0] m, input logic [3:0] c, input logic [31:0] ist, input bit stop);
    wr(OFS_MODE, {30'h0, m});
    wr(OFS_CMD, {28'h0, c});
    chk("fetch", {31'h0, m == MODE_DATA_PE}, {31'h0, code_fetch_ok_o});
    // Only one write fits inside the run: a stop, or a command that must be ignored
    if (stop) wr(OFS_STOP, 32'h1);
    else wr(OFS_CMD, {28'h0, CMD_BLANK});
    wait_idle();
    rd(OFS_IRQST);
    chk("irq status", ist, d);
  endtask

  task t_cmds;
    logic [3:0] codes [4] = '{CMD_PROGRAM, CMD_BLANK, CMD_BLOCK_ERASE, CMD_ALL_ERASE};
    wr(OFS_IRQMSK, 32'h3);
    wr(OFS_START, 32'h0000_FFFC);
    foreach (codes[i]) begin
      run(MODE_CODE_PE, codes[i], 32'h1, 1'b0);
      rd(OFS_STATUS);
      chk("failed", 32'h0, {31'h0, d[1]});
    end
    run(MODE_CODE_PE, 4'h2, 32'h1, 1'b0);
    rd(OFS_STATUS);
    chk("failed bad", 32'h1, {31'h0, d[1]});
    rd(OFS_ERRADR);
    chk("erradr", 32'h0000_FFFC, d);
    run(MODE_DATA_PE, CMD_PROGRAM, 32'h1, 1'b0);
    run(MODE_CODE_PE, CMD_PROGRAM, 32'h2, 1'b1);
    wr(OFS_IRQMSK, 32'h0);
    wr(OFS_CMD, {28'h0, CMD_PROGRAM});
    wr(OFS_WBUF0, 32'h0);
    wait_idle();
    chk("irq masked", 32'h0, {31'h0, sequencer_ready_irq});
    wr(OFS_IRQMSK, 32'h1);
    chk("irq", 32'h1, {31'h0, sequencer_ready_irq});
    rd(OFS_IRQST);
    chk("irq cleared", 32'h0, {31'h0, sequencer_ready_irq});
    rd(OFS_WBUF0);
    chk("wbuf busy", 32'hFFFFFFFF, d);
  endtask

  task t_extra;
    wr(OFS_START, 32'h2);
    wr(OFS_EXCMD, {29'h0, EXCMD_STARTUP});
    wait_idle();
    rd(OFS_SECMON);
    chk("window flag", 32'h1, d);
    wr(OFS_START, 32'h5);
    wr(OFS_END, 32'h9);
    wr(OFS_EXCMD, {29'h0, EXCMD_WINDOW});
    wait_idle();
    rd(OFS_PROT);
    chk("window", 32'h0009_0005, d);
  endtask

  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_regs();
    t_cmds();
    t_extra();
    conclude();
  end
endmodule // tb_flash_program_erase_sequencer
